/* rbl_defs.vh */
`ifndef RBL_DEFS_VH
`define RBL_DEFS_VH
// =====================================================
// serial word layout
`define RBL_WORD_BITS 16
`define RBL_BIT_DAC_WRITE 15
`define RBL_ADDR_HI 14
`define RBL_ADDR_LO 11
`define RBL_ADDR_MODE 4'h7
`define RBL_BIT_EN 6
`define RBL_SEL_HI 5
`define RBL_SEL_LO 2
`define RBL_MODE_HI 1
`define RBL_MODE_LO 0
`define RBL_CH_HI 14
`define RBL_CH_LO 12
`define RBL_DATA_HI 11
`define RBL_DATA_LO 0
// =====================================================
// selector codes
`define RBL_SEL_NOP 4'h0
`define RBL_SEL_MODE 4'h7
`define RBL_SEL_RESERVED 4'hE
// =====================================================
// load modes
`define RBL_LD_DIRECT 2'h0
`define RBL_LD_HOLD 2'h1
`define RBL_LD_ALL 2'h2
`define RBL_LD_RESERVED 2'h3
`define RBL_MODE_RESET 7'h00
// =====================================================
// bus register offsets
`define RBL_OFF_CTRL 8'h00
`define RBL_OFF_RXWORD 8'h04
`define RBL_OFF_DACIN 8'h08
`define RBL_OFF_DACREG 8'h20
`define RBL_OFF_INREG 8'h40
`define RBL_RESP_OKAY 2'h0
`define RBL_RESP_SLVERR 2'h2
`endif

/* rbl_host_model.sv */
// ==========================================
// serial host: frames words on the four pins
module rbl_host_model (
   output logic sclk,
   output logic sdi,
   output logic sync_n,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle: clock high, frame inactive
   initial begin
      sclk = 1'b1;
      sdi = 1'b0;
      sync_n = 1'b1;
   end
   // msb first, sdi steady across each falling edge; nb < 16 cuts the frame short
   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
      r = 16'h0000;
      #13 sync_n = 1'b0;
      for (int i = 15; i > 15 - nb; i--) begin
         sdi = w[i];
         #32 r[i] = sdo;
         sclk = 1'b0;
         #32 sclk = 1'b1;
      end
      sync_n = 1'b1;
      sdi = ~sdi; // released line flips
      #40;
   endtask
endmodule // rbl_host_model

/* rbl_serial.v */
`include "rbl_defs.vh"
// =====================================================
// four-wire serial shifter, pins sampled by aclk
module rbl_serial (
   input wire aclk,
   input wire aresetn,
   input wire sclk,
   input wire sdi,
   input wire sync_n,
   input wire [15:0] tx_word,
   output reg sdo,
   output reg rx_done,
   output reg [15:0] rx_word
);
   reg [2:0] meta;
   reg [2:0] stab;
   reg sclk_d;
   reg sync_d;
   reg [15:0] rx_sh;
   reg [15:0] tx_sh;
   reg [4:0] cnt;
   wire sclk_s = stab[2];
   wire sdi_s = stab[1];
   wire sync_s = stab[0];
   wire frame_start = sync_d & ~sync_s;
   wire fall = sclk_d & ~sclk_s & ~sync_s;
   wire rise = ~sclk_d & sclk_s & ~sync_s;
   // two-stage synchronisers for the pins
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta <= 3'h5;
         stab <= 3'h5;
         sclk_d <= 1'b1;
         sync_d <= 1'b1;
      end else begin
         meta <= {sclk, sdi, sync_n};
         stab <= meta;
         sclk_d <= sclk_s;
         sync_d <= sync_s;
      end
   end
   // shift in on falling sclk, out on rising sclk
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_sh <= 16'h0000;
         tx_sh <= 16'h0000;
         cnt <= 5'h00;
         sdo <= 1'b0;
         rx_done <= 1'b0;
         rx_word <= 16'h0000;
      end else begin
         rx_done <= 1'b0;
         if (frame_start) begin
            cnt <= 5'h00;
            tx_sh <= {tx_word[14:0], 1'b0};
            sdo <= tx_word[15];
         end else begin
            if (fall && cnt < 5'h10) begin
               rx_sh <= {rx_sh[14:0], sdi_s};
               cnt <= cnt + 5'h01;
               if (cnt == 5'h0F) begin
                  rx_done <= 1'b1;
                  rx_word <= {rx_sh[14:0], sdi_s};
               end
            end
            if (rise && cnt != 5'h00 && cnt < 5'h10) begin
               sdo <= tx_sh[15];
               tx_sh <= {tx_sh[14:0], 1'b0};
            end
         end
      end
   end
endmodule // rbl_serial

/* rbl_top.v */
`include "rbl_defs.vh"
module rbl_top (
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // serial pins
   input wire sclk,
   input wire sdi,
   input wire sync_n,
   output wire sdo,
   // other device registers, 16 words indexed by selector
   input wire [255:0] reg_bank,
   output reg [15:0] rx_word,
   output reg rx_valid,
   output reg [95:0] dac_out,
   output reg dac_update,
   output wire [1:0] dac_load_mode
);
   reg [6:0] mode_reg;
   reg rb_armed;
   reg [15:0] rb_word;
   reg [95:0] dac_in;
   reg [7:0] aw_addr;
   reg aw_full;
   reg [31:0] w_data;
   reg w_full;
   reg [3:0] w_strb;
   wire ser_done;
   wire [15:0] ser_word;
   wire [15:0] tx_word = rb_armed ? rb_word : 16'h0000;
   assign dac_load_mode = mode_reg[`RBL_MODE_HI:`RBL_MODE_LO];
   // =====================================================
   // serial port
   rbl_serial u_serial (
      .aclk(aclk),
      .aresetn(aresetn),
      .sclk(sclk),
      .sdi(sdi),
      .sync_n(sync_n),
      .tx_word(tx_word),
      .sdo(sdo),
      .rx_done(ser_done),
      .rx_word(ser_word)
   );
   // =====================================================
   // command decode, serial first, bus when serial idle
   wire [15:0] axi_mode_word = {1'b0, `RBL_ADDR_MODE, 4'h0, w_data[6:0]};
   wire [15:0] axi_dac_word = {1'b1, w_data[14:0]};
   wire bus_wr = aw_full & w_full & ~s_axi_bvalid & ~ser_done;
   // an empty strobe turns the write into a refused no-op
   wire bus_strb = w_strb != 4'h0;
   wire bus_hit_ctrl = bus_wr && bus_strb && aw_addr == `RBL_OFF_CTRL;
   wire bus_hit_dac = bus_wr && bus_strb && aw_addr == `RBL_OFF_DACIN;
   wire cmd_valid = ser_done | bus_hit_ctrl | bus_hit_dac;
   wire [15:0] cmd = ser_done ? ser_word : (bus_hit_ctrl ? axi_mode_word : axi_dac_word);
   wire cmd_dac = cmd_valid & cmd[`RBL_BIT_DAC_WRITE];
   wire cmd_mode = cmd_valid & ~cmd[`RBL_BIT_DAC_WRITE] &
      (cmd[`RBL_ADDR_HI:`RBL_ADDR_LO] == `RBL_ADDR_MODE);
   wire [2:0] cmd_ch = cmd[`RBL_CH_HI:`RBL_CH_LO];
   wire [11:0] cmd_data = cmd[`RBL_DATA_HI:`RBL_DATA_LO];
   wire [1:0] cmd_ld = cmd[`RBL_MODE_HI:`RBL_MODE_LO];
   wire [3:0] cmd_sel = cmd[`RBL_SEL_HI:`RBL_SEL_LO];
   wire cmd_en = cmd[`RBL_BIT_EN];
   // =====================================================
   // readback word chosen at the moment of the request
   reg [15:0] sel_word;
   always @* begin
      case (cmd_sel)
         `RBL_SEL_NOP: sel_word = 16'h0000;
         `RBL_SEL_MODE: sel_word = {9'h000, mode_reg};
         `RBL_SEL_RESERVED: sel_word = 16'h0000;
         default: sel_word = reg_bank[cmd_sel*16 +: 16];
      endcase
   end
   // =====================================================
   // mode register and readback arming
   always @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= `RBL_MODE_RESET;
         rb_armed <= 1'b0;
         rb_word <= 16'h0000;
      end else if (cmd_mode) begin
         mode_reg <= cmd[6:0];
         if (cmd_en) begin
            rb_armed <= 1'b1;
            rb_word <= sel_word;
         end else if (ser_done) begin
            rb_armed <= 1'b0;
         end
      end else if (ser_done && rb_armed) begin
         rb_armed <= 1'b0;
         mode_reg[`RBL_BIT_EN] <= 1'b0;
      end
   end
   // =====================================================
   // dac input and dac registers
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ch
         localparam [2:0] ch_idx = g;
         always @(posedge aclk) begin
            if (!aresetn) begin
               dac_in[g*12 +: 12] <= 12'h000;
               dac_out[g*12 +: 12] <= 12'h000;
            end else begin
               if (cmd_dac && cmd_ch == ch_idx) begin
                  dac_in[g*12 +: 12] <= cmd_data;
                  if (dac_load_mode == `RBL_LD_DIRECT)
                     dac_out[g*12 +: 12] <= cmd_data;
               end else if (cmd_mode && cmd_ld == `RBL_LD_ALL) begin
                  dac_out[g*12 +: 12] <= dac_in[g*12 +: 12];
               end
            end
         end
      end
   endgenerate
   // output update strobe and received word
   always @(posedge aclk) begin
      if (!aresetn) begin
         dac_update <= 1'b0;
         rx_valid <= 1'b0;
         rx_word <= 16'h0000;
      end else begin
         dac_update <= (cmd_dac && dac_load_mode == `RBL_LD_DIRECT) ||
            (cmd_mode && cmd_ld == `RBL_LD_ALL);
         rx_valid <= ser_done;
         if (ser_done)
            rx_word <= ser_word;
      end
   end
   // =====================================================
   // axi4-lite write channel
   assign s_axi_awready = ~aw_full;
   assign s_axi_wready = ~w_full;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RBL_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb; // strobe only valid with wvalid
         end
         if (bus_wr) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (bus_hit_ctrl || bus_hit_dac) ? `RBL_RESP_OKAY : `RBL_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // =====================================================
   // axi4-lite read channel
   assign s_axi_arready = ~s_axi_rvalid;
   wire [2:0] rd_ch = s_axi_araddr[4:2];
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RBL_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RBL_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         if ({s_axi_araddr[7:2], 2'h0} == `RBL_OFF_CTRL)
            s_axi_rdata <= {25'h0000000, mode_reg};
         else if ({s_axi_araddr[7:2], 2'h0} == `RBL_OFF_RXWORD)
            s_axi_rdata <= {16'h0000, rx_word};
         else if ({s_axi_araddr[7:5], 5'h00} == `RBL_OFF_DACREG)
            s_axi_rdata <= {20'h00000, dac_out[rd_ch*12 +: 12]};
         else if ({s_axi_araddr[7:5], 5'h00} == `RBL_OFF_INREG)
            s_axi_rdata <= {20'h00000, dac_in[rd_ch*12 +: 12]};
         else
            s_axi_rresp <= `RBL_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // rbl_top

/* rbl_top_monitor.sv */
// ==========================================
// checker on the load and link ports
module rbl_top_monitor (
   input wire aclk,
   input wire aresetn,
   input wire sclk,
   input wire [15:0] rx_word,
   input wire rx_valid,
   input wire [95:0] dac_out,
   input wire dac_update,
   input wire [1:0] dac_load_mode
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // no update strobe for three cycles
   sequence s_quiet;
      !dac_update [*3];
   endsequence
   // a completed mode-register word
   sequence s_mode_wr;
      rx_valid && rx_word[15:11] == 5'h07;
   endsequence
   chk_mode_reset: assert property ($rose(aresetn) |-> dac_load_mode == 2'h0)
      else $error("load mode not default");
   chk_out_strobe: assert property (!$stable(dac_out) |-> dac_update)
      else $error("dac change without update");
   chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
      else $error("word strobe too long");
   chk_rx_sclk_low: assert property (rx_valid |-> !sclk)
      else $error("word not ended by falling clock");
   chk_direct_load: assert property (rx_valid && rx_word[15] && dac_load_mode == 2'h0 |-> ##[0:2] dac_update)
      else $error("direct write not loaded");
   chk_hold_load: assert property (rx_valid && rx_word[15] && dac_load_mode == 2'h1 |-> s_quiet)
      else $error("held write loaded");
   chk_load_all: assert property (dac_load_mode == 2'h2 && $past(dac_load_mode) != 2'h2 |-> ##[0:2] dac_update)
      else $error("joint load missing");
   chk_mode_apply: assert property (s_mode_wr ##0 rx_word[1:0] != 2'h3 |-> ##[0:2] dac_load_mode == rx_word[1:0])
      else $error("load mode not applied");
   chk_mode_rsvd: assert property (s_mode_wr ##0 rx_word[1:0] == 2'h3 |-> s_quiet)
      else $error("reserved mode loaded");
endmodule // rbl_top_monitor
bind rbl_top rbl_top_monitor u_mon (
   .aclk(aclk),
   .aresetn(aresetn),
   .sclk(sclk),
   .rx_word(rx_word),
   .rx_valid(rx_valid),
   .dac_out(dac_out),
   .dac_update(dac_update),
   .dac_load_mode(dac_load_mode)
);

/* testbench.sv */
`include "rbl_defs.vh"
// ==========================================
// bench top
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sclk, sdi, sync_n, sdo, rx_valid, dac_update;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, dac_load_mode, rs;
   logic [255:0] reg_bank;
   logic [15:0] rx_word, r;
   logic [95:0] dac_out;
   int failures, total_checks;
   rbl_top u_dut (.*);
   rbl_host_model u_host (.sclk(sclk), .sdi(sdi), .sync_n(sync_n), .sdo(sdo));
   // free-running clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one bus transfer; each channel dropped at the edge it is taken
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic done, ta, tw;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      for (int n = 0; n < 40 && !done; n++) begin
         @(negedge aclk);
         ta = wr ? s_axi_awready : s_axi_arready;
         tw = s_axi_wready;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         rs = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (ta) s_axi_arvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
      if (!done) begin
         failures++;
         complete_run;
      end
   endtask
   task automatic ser(input logic [15:0] w, input int nb);
      u_host.xfer(w, nb, r);
      repeat (4) @(posedge aclk);
   endtask
   task automatic t_reset;
      bus(1'b0, 8'h00, 32'h0);
      check(q, 32'h0);
      check(dac_load_mode, 2'h0);
      $display("t_reset done");
   endtask
   task automatic t_direct;
      ser(16'hAABC, 16);
      check(rx_word, 16'hAABC);
      bus(1'b0, 8'h28, 32'h0);
      check(q, 32'hABC);
      bus(1'b0, 8'h04, 32'h0);
      check(q, 32'hAABC);
      bus(1'b1, 8'h08, 32'h7456);
      check(rs, `RBL_RESP_OKAY);
      bus(1'b0, 8'h3C, 32'h0);
      check(q, 32'h456);
      $display("t_direct done");
   endtask
   task automatic t_hold;
      ser(16'h3801, 16);
      ser(16'hD123, 16);
      ser(16'h00F0, 8);
      check(rx_word, 16'hD123);
      bus(1'b0, 8'h54, 32'h0);
      check(q, 32'h123);
      bus(1'b0, 8'h34, 32'h0);
      check(q, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      check(q, 32'h1);
      $display("t_hold done");
   endtask
   task automatic t_all;
      bus(1'b1, 8'h00, 32'h2);
      check(rs, 2'h0);
      bus(1'b0, 8'h34, 32'h0);
      check(q, 32'h123);
      bus(1'b0, 8'h28, 32'h0);
      check(q, 32'hABC);
      ser(16'hF321, 16);
      bus(1'b0, 8'h3C, 32'h0);
      check(q, 32'h456);
      bus(1'b0, 8'h5C, 32'h0);
      check(q, 32'h321);
      $display("t_all done");
   endtask
   task automatic t_readback;
      for (int s = 7; s < 16; s++) begin
         ser(16'h3841 | 16'(s << 2), 16);
         ser(16'h0000, 16);
         check(r, s == 14 ? 16'h0 : (s == 7 ? 16'h0002 : 16'h5A00 | 16'(s)));
      end
      ser(16'h3841, 16);
      ser(16'h0000, 16);
      check(r, 16'h0000);
      bus(1'b0, 8'h00, 32'h0);
      check(q, 32'h1);
      $display("t_readback done");
   endtask
   task automatic t_reserved;
      ser(16'h8777, 16);
      ser(16'h3803, 16);
      bus(1'b0, 8'h20, 32'h0);
      check(q, 32'h0);
      s_axi_wstrb <= 4'h0;
      bus(1'b1, 8'h00, 32'h2);
      check(rs, `RBL_RESP_SLVERR);
      s_axi_wstrb <= 4'hF;
      bus(1'b0, 8'h00, 32'h0);
      check(q, 32'h3);
      bus(1'b0, 8'hFC, 32'h0);
      check(rs, `RBL_RESP_SLVERR);
      $display("t_reserved done");
   endtask
   // reset in mid-run brings back the default load mode and cleared outputs
   task automatic t_restart;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b0, 8'h3C, 32'h0);
      check(q, 32'h0);
      check(dac_load_mode, 2'h0);
      $display("t_restart done");
   endtask
   // reset, then the scenarios in order
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      failures = 0;
      total_checks = 0;
      for (int k = 0; k < 16; k++) reg_bank[k * 16 +: 16] = 16'h5A00 | 16'(k);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_direct;
      t_hold;
      t_all;
      t_readback;
      t_reserved;
      t_restart;
      complete_run;
   end
endmodule // testbench
